/* rtc_pkg.sv */
package rtc_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_KHZ = 25000;
	localparam int POR_TIME_MS = 250;
	localparam int WDT_SHORT_MS = 250;
	localparam int WDT_MID_MS = 750;
	localparam int WDT_LONG_MS = 1750;
	localparam int POR_CYC = POR_TIME_MS * CLK_KHZ;
	localparam int WDT_SHORT_CYC = WDT_SHORT_MS * CLK_KHZ;
	localparam int WDT_MID_CYC = WDT_MID_MS * CLK_KHZ;
	localparam int WDT_LONG_CYC = WDT_LONG_MS * CLK_KHZ;
	typedef logic [25:0] cnt_t;

	// Crystal divider: 32768 edges per second
	localparam logic [14:0] DIV_LAST = 15'h7fff;
	localparam int DIV_4096_BIT = 2;
	localparam int DIV_1HZ_BIT = 14;

	// ----------------------------------------
	// Two-wire side
	// ----------------------------------------
	localparam logic [6:0] DEV_SEL = 7'h6f;
	localparam logic [7:0] ADDR_HI_OK = 8'h00;
	localparam logic [2:0] CLK_SECT = 3'h6;
	localparam logic [5:0] STATUS_ADDR = 6'h3f;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_DEV = 3'b001,
		I2C_AHI = 3'b010,
		I2C_ALO = 3'b011,
		I2C_WR = 3'b100,
		I2C_RD = 3'b101,
		I2C_MACK = 3'b110
	} i2c_st_t;

	// ----------------------------------------
	// Clock bytes: sec min hour date month year weekday century
	// ----------------------------------------
	localparam int T_SEC = 0;
	localparam int T_MIN = 1;
	localparam int T_HOUR = 2;
	localparam int T_DATE = 3;
	localparam int T_MON = 4;
	localparam int T_YEAR = 5;
	localparam int T_DOW = 6;
	localparam logic [63:0] TIME_RESET = 64'h2000_0001_0112_0000;

	// ----------------------------------------
	// Wishbone map
	// ----------------------------------------
	localparam logic [7:0] WB_CTRL = 8'h00;
	localparam logic [7:0] WB_ALM0_LO = 8'h04;
	localparam logic [7:0] WB_ALM0_HI = 8'h08;
	localparam logic [7:0] WB_ALM1_LO = 8'h0c;
	localparam logic [7:0] WB_ALM1_HI = 8'h10;
	localparam logic [7:0] WB_STATUS = 8'h14;
	localparam logic [7:0] WB_TIME_LO = 8'h18;
	localparam logic [7:0] WB_TIME_HI = 8'h1c;

	localparam int C_H24 = 0;
	localparam int C_IRQ = 1;
	localparam int C_FSEL = 2;
	localparam int C_THR = 4;
	localparam int C_WDT = 7;
	localparam int C_BUSRST = 9;
	localparam int C_ARM = 10;
	localparam int C_REP = 12;
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	localparam int ALM_EN = 16;

	localparam logic [1:0] FREQ_1HZ = 2'h1;
	localparam logic [1:0] FREQ_4096 = 2'h2;
	localparam logic [1:0] FREQ_32K = 2'h3;
	localparam logic [1:0] WDT_SHORT = 2'h1;
	localparam logic [1:0] WDT_MID = 2'h2;

	// Five supply thresholds, index 4 is the last
	localparam logic [2:0] THR_LAST = 3'h4;
	localparam logic [4:0][7:0] THR_TABLE = {8'hd0, 8'hb0, 8'h90, 8'h80, 8'h70};

endpackage

/* pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_state_t;

	sync_state_t sync_reg;
	sync_state_t sync_next;

	// Only the second stage reads the first one
	always_comb begin
		sync_next.first = async_i;
		sync_next.second = sync_reg.first;
	end

	// ----------------------------------------
	// Register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg.second;

endmodule

/* rtc_core.sv */
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module rtc_core #(
	parameter int POR_CYCLES = rtc_pkg::POR_CYC,
	parameter int WDT_SHORT_CYCLES = rtc_pkg::WDT_SHORT_CYC,
	parameter int WDT_MID_CYCLES = rtc_pkg::WDT_MID_CYC,
	parameter int WDT_LONG_CYCLES = rtc_pkg::WDT_LONG_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic xtal_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [7:0] supply_level_i,
	output logic alarm_irq_freq_out_o,
	output logic alarm_irq_freq_out_oe_o,
	output logic reset_out_o,
	output logic reset_out_oe_o
);

	typedef struct packed {
		logic [2:0] pins_prev;
		logic [14:0] div;
		logic tick_d;
		logic [7:0][7:0] tm;
		logic [7:0][7:0] snap;
		logic [7:0][7:0] hold;
		logic halted;
		logic load_pend;
		logic [1:0] flag;
		logic [1:0] fcap;
		logic [13:0] ctrl;
		logic [3:0][31:0] alm;
		rtc_pkg::i2c_st_t st;
		logic in_ack;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [5:0] addr;
		logic rw;
		logic hi_ok;
		logic wr_seen;
		logic wr_bad;
		logic mack;
		logic is_stat;
		logic sda_oe;
		rtc_pkg::cnt_t hold_cnt;
		rtc_pkg::cnt_t wdt_cnt;
		logic rst_act;
		logic out_oe;
		logic ack;
		logic [31:0] dat;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic [2:0] syn;
	logic xtal_rise;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic sec_tick;
	logic bus_ok;
	logic wb_req;
	logic [2:0] thr_idx;
	logic supply_low;
	logic [1:0] wdt_sel;
	rtc_pkg::cnt_t wdt_lim;

	// ----------------------------------------
	// Pin synchronisers: crystal, clock, data
	// ----------------------------------------
	pin_sync #(
		.W(3)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i({sda_i, scl_i, xtal_i}),
		.sync_o(syn)
	);

	// Edge and condition detection on synchronised pins
	assign xtal_rise = syn[0] & ~state_reg.pins_prev[0];
	assign scl_rise = syn[1] & ~state_reg.pins_prev[1];
	assign scl_fall = ~syn[1] & state_reg.pins_prev[1];
	assign start_ev = syn[1] & state_reg.pins_prev[1] & state_reg.pins_prev[2] & ~syn[2];
	assign stop_ev = syn[1] & state_reg.pins_prev[1] & ~state_reg.pins_prev[2] & syn[2];
	assign sec_tick = xtal_rise & (state_reg.div == rtc_pkg::DIV_LAST);
	assign bus_ok = ~state_reg.rst_act | state_reg.ctrl[rtc_pkg::C_BUSRST];
	assign wb_req = wb_cyc_i & wb_stb_i;

	// Supply compare against the selected level
	assign thr_idx = (state_reg.ctrl[rtc_pkg::C_THR +: 3] > rtc_pkg::THR_LAST) ? rtc_pkg::THR_LAST
		: state_reg.ctrl[rtc_pkg::C_THR +: 3];
	assign supply_low = supply_level_i < rtc_pkg::THR_TABLE[thr_idx];
	assign wdt_sel = state_reg.ctrl[rtc_pkg::C_WDT +: 2];

	// Watchdog limit per setting
	always_comb begin
		case (wdt_sel)
			rtc_pkg::WDT_SHORT: wdt_lim = rtc_pkg::cnt_t'(WDT_SHORT_CYCLES);
			rtc_pkg::WDT_MID: wdt_lim = rtc_pkg::cnt_t'(WDT_MID_CYCLES);
			default: wdt_lim = rtc_pkg::cnt_t'(WDT_LONG_CYCLES);
		endcase
	end

	// ----------------------------------------
	// Calendar helpers
	// ----------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Leap when the BCD year divides by four
	function automatic logic [7:0] month_last(input logic [7:0] mo, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mo)
			8'h02: month_last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
			default: month_last = 8'h31;
		endcase
	endfunction

	function automatic logic [7:0][7:0] advance(input logic [7:0][7:0] t, input logic h24);
		logic [7:0][7:0] n;
		logic day;
		logic pm;
		logic [7:0] hb;
		n = t;
		hb = 8'h00;
		day = 1'b0;
		pm = t[rtc_pkg::T_HOUR][5];
		if (t[rtc_pkg::T_SEC] != 8'h59) begin
			n[rtc_pkg::T_SEC] = bcd_inc(t[rtc_pkg::T_SEC]);
		end else begin
			n[rtc_pkg::T_SEC] = 8'h00;
			if (t[rtc_pkg::T_MIN] != 8'h59) begin
				n[rtc_pkg::T_MIN] = bcd_inc(t[rtc_pkg::T_MIN]);
			end else begin
				n[rtc_pkg::T_MIN] = 8'h00;
				if (h24) begin
					// 24-hour: 00..23
					if (t[rtc_pkg::T_HOUR][5:0] == 6'h23) begin
						n[rtc_pkg::T_HOUR] = 8'h80;
						day = 1'b1;
					end else begin
						hb = bcd_inc({2'b00, t[rtc_pkg::T_HOUR][5:0]});
						n[rtc_pkg::T_HOUR] = {2'b10, hb[5:0]};
					end
				end else begin
					// 12-hour: 12,1..11 with the afternoon bit
					if (t[rtc_pkg::T_HOUR][4:0] == 5'h11) begin
						n[rtc_pkg::T_HOUR] = {2'b00, ~pm, 5'h12};
						day = pm;
					end else if (t[rtc_pkg::T_HOUR][4:0] == 5'h12) begin
						n[rtc_pkg::T_HOUR] = {2'b00, pm, 5'h01};
					end else begin
						hb = bcd_inc({3'b000, t[rtc_pkg::T_HOUR][4:0]});
						n[rtc_pkg::T_HOUR] = {2'b00, pm, hb[4:0]};
					end
				end
			end
		end
		if (day) begin
			n[rtc_pkg::T_DOW] = (t[rtc_pkg::T_DOW] == 8'h06) ? 8'h00 : bcd_inc(t[rtc_pkg::T_DOW]);
			if (t[rtc_pkg::T_DATE] == month_last(t[rtc_pkg::T_MON], t[rtc_pkg::T_YEAR])) begin
				n[rtc_pkg::T_DATE] = 8'h01;
				if (t[rtc_pkg::T_MON] == 8'h12) begin
					n[rtc_pkg::T_MON] = 8'h01;
					// Century byte stays put: good through 2099
					n[rtc_pkg::T_YEAR] = (t[rtc_pkg::T_YEAR] == 8'h99) ? 8'h00 : bcd_inc(t[rtc_pkg::T_YEAR]);
				end else begin
					n[rtc_pkg::T_MON] = bcd_inc(t[rtc_pkg::T_MON]);
				end
			end else begin
				n[rtc_pkg::T_DATE] = bcd_inc(t[rtc_pkg::T_DATE]);
			end
		end
		advance = n;
	endfunction

	// Byte served on the serial side
	function automatic logic [7:0] out_byte(input logic [5:0] a, input logic [7:0][7:0] t,
			input logic [1:0] f, input logic h);
		if (a == rtc_pkg::STATUS_ADDR) begin
			out_byte = {1'b0, f[1], f[0], 4'h0, h};
		end else if (a[5:3] == rtc_pkg::CLK_SECT) begin
			out_byte = t[a[2:0]];
		end else begin
			out_byte = 8'h00;
		end
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] ob;
		logic [7:0][7:0] t;
		logic [5:0] hit;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] mw;
		ob = 8'h00;
		t = state_reg.tm;
		hit = 6'h00;
		lo = 32'h0;
		hi = 32'h0;
		// Control word with the byte lanes of a bus write merged in
		mw = merge({18'h0, state_reg.ctrl}, wb_dat_i, wb_sel_i);
		state_next = state_reg;
		state_next.pins_prev = syn;
		state_next.tick_d = sec_tick;

		// Divider chain, one count per crystal edge
		if (xtal_rise) begin
			state_next.div = state_reg.div + 15'h0001;
		end

		// Second tick: load a finished write or count on; never stalled by the bus
		if (sec_tick) begin
			if (state_reg.load_pend) begin
				state_next.tm = state_reg.hold;
				state_next.halted = 1'b0;
				state_next.load_pend = 1'b0;
			end else if (!state_reg.halted) begin
				state_next.tm = advance(state_reg.tm, state_reg.ctrl[rtc_pkg::C_H24]);
			end
		end

		// Supervisor: power-on hold and watchdog share one hold counter
		if (supply_low) begin
			state_next.hold_cnt = '0;
			state_next.wdt_cnt = '0;
		end else if (state_reg.hold_cnt != rtc_pkg::cnt_t'(POR_CYCLES)) begin
			state_next.hold_cnt = state_reg.hold_cnt + 26'h1;
			state_next.wdt_cnt = '0;
		end else if (wdt_sel == 2'h0 || start_ev) begin
			state_next.wdt_cnt = '0;
		end else if (state_reg.wdt_cnt == wdt_lim - 26'h1) begin
			state_next.wdt_cnt = '0;
			state_next.hold_cnt = '0;
		end else begin
			state_next.wdt_cnt = state_reg.wdt_cnt + 26'h1;
		end
		state_next.rst_act = state_next.hold_cnt != rtc_pkg::cnt_t'(POR_CYCLES);

		// Serial slave; with C_BUSRST clear, a reset window drops any transfer in flight
		if (!bus_ok) begin
			state_next.st = rtc_pkg::I2C_IDLE;
			state_next.sda_oe = 1'b0;
			state_next.in_ack = 1'b0;
			state_next.wr_seen = 1'b0;
			state_next.wr_bad = 1'b0;
		end else if (start_ev) begin
			// A restart before stop throws away buffered time
			state_next.st = rtc_pkg::I2C_DEV;
			state_next.cnt = 4'h0;
			state_next.in_ack = 1'b0;
			state_next.sda_oe = 1'b0;
			state_next.wr_seen = 1'b0;
			state_next.wr_bad = 1'b0;
		end else if (stop_ev) begin
			if (state_reg.wr_seen && !state_reg.wr_bad) begin
				state_next.load_pend = 1'b1;
			end
			state_next.st = rtc_pkg::I2C_IDLE;
			state_next.sda_oe = 1'b0;
			state_next.wr_seen = 1'b0;
			state_next.wr_bad = 1'b0;
		end else begin
			case (state_reg.st)
				rtc_pkg::I2C_DEV, rtc_pkg::I2C_AHI, rtc_pkg::I2C_ALO, rtc_pkg::I2C_WR: begin
					if (!state_reg.in_ack) begin
						if (scl_rise) begin
							state_next.shift = {state_reg.shift[6:0], syn[2]};
							state_next.cnt = state_reg.cnt + 4'h1;
						end else if (scl_fall && state_reg.cnt == 4'h8) begin
							state_next.in_ack = 1'b1;
							state_next.cnt = 4'h0;
							state_next.sda_oe = 1'b1;
							if (state_reg.st == rtc_pkg::I2C_DEV) begin
								state_next.rw = state_reg.shift[0];
								if (state_reg.shift[7:1] != rtc_pkg::DEV_SEL) begin
									state_next.st = rtc_pkg::I2C_IDLE;
									state_next.sda_oe = 1'b0;
									state_next.in_ack = 1'b0;
								end
							end else if (state_reg.st == rtc_pkg::I2C_AHI) begin
								state_next.hi_ok = state_reg.shift == rtc_pkg::ADDR_HI_OK;
							end else if (state_reg.st == rtc_pkg::I2C_ALO) begin
								state_next.addr = state_reg.shift[5:0];
							end
						end
					end else if (scl_fall) begin
						state_next.in_ack = 1'b0;
						state_next.sda_oe = 1'b0;
						case (state_reg.st)
							rtc_pkg::I2C_DEV: begin
								if (state_reg.rw) begin
									// Freeze the time at the fall ending this ack
									state_next.snap = state_reg.tm;
									ob = out_byte(state_reg.addr, state_reg.tm, state_reg.flag, state_reg.halted);
									state_next.st = rtc_pkg::I2C_RD;
									state_next.shift = ob;
									state_next.sda_oe = ~ob[7];
									state_next.cnt = 4'h0;
									state_next.is_stat = state_reg.addr == rtc_pkg::STATUS_ADDR;
									state_next.fcap = state_reg.flag;
								end else begin
									state_next.st = rtc_pkg::I2C_AHI;
								end
							end
							rtc_pkg::I2C_AHI: state_next.st = rtc_pkg::I2C_ALO;
							rtc_pkg::I2C_ALO: begin
								state_next.st = rtc_pkg::I2C_WR;
								state_next.hold = state_reg.tm;
								state_next.wr_bad = ~state_reg.hi_ok;
							end
							default: begin
								// Byte captured into the buffer at the ack fall
								if (state_reg.addr[5:3] == rtc_pkg::CLK_SECT) begin
									state_next.hold[state_reg.addr[2:0]] = state_reg.shift;
									state_next.wr_seen = 1'b1;
								end else begin
									state_next.wr_bad = 1'b1;
								end
								state_next.addr = state_reg.addr + 6'h01;
							end
						endcase
					end
				end
				rtc_pkg::I2C_RD: begin
					if (scl_fall) begin
						state_next.cnt = state_reg.cnt + 4'h1;
						if (state_reg.cnt == 4'h7) begin
							state_next.sda_oe = 1'b0;
							state_next.st = rtc_pkg::I2C_MACK;
							state_next.addr = state_reg.addr + 6'h01;
							if (state_reg.is_stat) begin
								// Only flags seen at byte start are cleared
								state_next.flag = state_reg.flag & ~state_reg.fcap;
							end
						end else begin
							state_next.sda_oe = ~state_reg.shift[6];
							state_next.shift = {state_reg.shift[6:0], 1'b0};
						end
					end
				end
				rtc_pkg::I2C_MACK: begin
					if (scl_rise) begin
						state_next.mack = ~syn[2];
					end else if (scl_fall) begin
						if (state_reg.mack && !state_reg.is_stat) begin
							ob = out_byte(state_reg.addr, state_reg.snap, state_reg.flag, state_reg.halted);
							state_next.st = rtc_pkg::I2C_RD;
							state_next.shift = ob;
							state_next.sda_oe = ~ob[7];
							state_next.cnt = 4'h0;
							state_next.is_stat = state_reg.addr == rtc_pkg::STATUS_ADDR;
							state_next.fcap = state_reg.flag;
						end else begin
							state_next.st = rtc_pkg::I2C_IDLE;
						end
					end
				end
				default: begin
					state_next.sda_oe = 1'b0;
				end
			endcase
		end

		// Alarms checked on the cycle after the time moved; reads do not block this
		if (state_reg.tick_d) begin
			for (int a = 0; a < 2; a++) begin
				lo = state_reg.alm[2*a];
				hi = state_reg.alm[2*a + 1];
				hit[0] = lo[7:0] == t[rtc_pkg::T_SEC];
				hit[1] = lo[15:8] == t[rtc_pkg::T_MIN];
				hit[2] = lo[21:16] == t[rtc_pkg::T_HOUR][5:0];
				hit[3] = lo[31:24] == t[rtc_pkg::T_DATE];
				hit[4] = hi[7:0] == t[rtc_pkg::T_MON];
				hit[5] = hi[10:8] == t[rtc_pkg::T_DOW][2:0];
				if (state_reg.ctrl[rtc_pkg::C_ARM + a] && hi[rtc_pkg::ALM_EN +: 6] != 6'h00
						&& (hit | ~hi[rtc_pkg::ALM_EN +: 6]) == 6'h3f) begin
					state_next.flag[a] = 1'b1;
					if (!state_reg.ctrl[rtc_pkg::C_REP + a]) begin
						state_next.ctrl[rtc_pkg::C_ARM + a] = 1'b0;
					end
				end
			end
		end

		// Shared output: alarm level, a tap of the divider chain, or the synchronised crystal
		if (state_reg.ctrl[rtc_pkg::C_IRQ]) begin
			state_next.out_oe = |state_reg.flag;
		end else begin
			case (state_reg.ctrl[rtc_pkg::C_FSEL +: 2])
				rtc_pkg::FREQ_1HZ: state_next.out_oe = ~state_reg.div[rtc_pkg::DIV_1HZ_BIT];
				rtc_pkg::FREQ_4096: state_next.out_oe = ~state_reg.div[rtc_pkg::DIV_4096_BIT];
				rtc_pkg::FREQ_32K: state_next.out_oe = ~syn[0];
				default: state_next.out_oe = 1'b0;
			endcase
		end

		// Wishbone: ack one cycle after request, write at the ack edge
		state_next.ack = wb_req & ~state_reg.ack;
		if (wb_req && !state_reg.ack) begin
			case (wb_adr_i & 8'hfc)
				rtc_pkg::WB_CTRL: state_next.dat = {18'h0, state_reg.ctrl};
				rtc_pkg::WB_ALM0_LO: state_next.dat = state_reg.alm[0];
				rtc_pkg::WB_ALM0_HI: state_next.dat = state_reg.alm[1];
				rtc_pkg::WB_ALM1_LO: state_next.dat = state_reg.alm[2];
				rtc_pkg::WB_ALM1_HI: state_next.dat = state_reg.alm[3];
				rtc_pkg::WB_STATUS: state_next.dat = {27'h0, supply_low, state_reg.rst_act,
					state_reg.flag, state_reg.halted};
				rtc_pkg::WB_TIME_LO: state_next.dat = state_reg.tm[3:0];
				rtc_pkg::WB_TIME_HI: state_next.dat = state_reg.tm[7:4];
				default: state_next.dat = 32'h0;
			endcase
		end
		if (wb_req && state_reg.ack && wb_we_i) begin
			case (wb_adr_i & 8'hfc)
				rtc_pkg::WB_CTRL: state_next.ctrl = mw[13:0];
				rtc_pkg::WB_ALM0_LO: state_next.alm[0] = merge(state_reg.alm[0], wb_dat_i, wb_sel_i);
				rtc_pkg::WB_ALM0_HI: state_next.alm[1] = merge(state_reg.alm[1], wb_dat_i, wb_sel_i);
				rtc_pkg::WB_ALM1_LO: state_next.alm[2] = merge(state_reg.alm[2], wb_dat_i, wb_sel_i);
				rtc_pkg::WB_ALM1_HI: state_next.alm[3] = merge(state_reg.alm[3], wb_dat_i, wb_sel_i);
				default: state_next.dat = state_next.dat;
			endcase
		end
	end

	// ----------------------------------------
	// Register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.tm <= rtc_pkg::TIME_RESET;
			state_reg.halted <= 1'b1;
			state_reg.ctrl <= rtc_pkg::CTRL_RESET;
			state_reg.rst_act <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Open-drain pins only ever pull low
	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.dat;
	assign sda_o = 1'b0;
	assign sda_oe_o = state_reg.sda_oe;
	assign alarm_irq_freq_out_o = 1'b0;
	assign alarm_irq_freq_out_oe_o = state_reg.out_oe;
	assign reset_out_o = 1'b0;
	assign reset_out_oe_o = state_reg.rst_act;

endmodule

/* rtc_chk.sv */
`timescale 1ns/1ns
// ------------------------------
// Port checker for the clock core
// ------------------------------
module rtc_chk #(
	parameter int POR_CYCLES = 200
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [7:0] supply_level_i,
	input wire logic alarm_irq_freq_out_o,
	input wire logic reset_out_o,
	input wire logic reset_out_oe_o
);
	int por_cnt;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_idle;
		!(wb_cyc_i && wb_stb_i);
	endsequence
	// Cycles since reset release; saturates so a later supply dip cannot fake a hold
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			por_cnt <= 0;
		else if (por_cnt < POR_CYCLES)
			por_cnt <= por_cnt + 1;
	end
	a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("ack missing");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_needs_req: assert property (s_idle |=> !wb_ack_o) else $error("ack without request");
	a_dat_holds: assert property (s_idle |=> $stable(wb_dat_o)) else $error("read data moved");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && reset_out_oe_o) else $error("reset state");
	a_por_hold: assert property (por_cnt < POR_CYCLES - 1 |-> reset_out_oe_o) else $error("early release");
	a_supply_low: assert property (supply_level_i < 8'h70 |-> ##[1:3] reset_out_oe_o) else $error("no reset");
	a_pins_drain: assert property (!sda_o && !reset_out_o && !alarm_irq_freq_out_o) else $error("pin driven");
endmodule

/* i2c_host.sv */
`timescale 1ns/1ns
// ------------------------------
// Two-wire bus master, SDA with pull-up
// ------------------------------
module i2c_host (
	input wire logic core_clk_i,
	input wire logic sda_oe_i,
	output logic scl_o,
	output logic sda_o
);
	logic pull_low;
	// Wired level: high unless a party pulls low
	assign sda_o = !(pull_low || sda_oe_i);
	initial begin
		scl_o = 1'b1;
		pull_low = 1'b0;
	end
	task automatic q();
		repeat (2) @(posedge core_clk_i);
	endtask
	// Extra quarter lets the slave drop its ack before SCL rises
	task automatic start();
		pull_low <= 1'b0;
		q();
		q();
		scl_o <= 1'b1;
		q();
		pull_low <= 1'b1;
		q();
		scl_o <= 1'b0;
		q();
	endtask
	task automatic stop();
		pull_low <= 1'b1;
		q();
		scl_o <= 1'b1;
		q();
		pull_low <= 1'b0;
		q();
	endtask
	// Eight bits MSB first then the ack slot; rel releases the ninth bit
	task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] r, output logic ackd);
		logic [8:0] s;
		for (int i = 8; i >= 0; i--) begin
			pull_low <= (i > 0) ? !d[i-1] : !rel;
			q();
			scl_o <= 1'b1;
			q();
			s[i] = sda_o;
			q();
			scl_o <= 1'b0;
			q();
		end
		r = s[8:1];
		ackd = !s[0];
	endtask
endmodule

/* tb.sv */
`timescale 1ns/1ns
// ------------------------------
// Register and wire tests
// ------------------------------
module tb;
	logic core_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, xtal_i, scl_i, sda_i, sda_o, sda_oe_o;
	logic alarm_irq_freq_out_o, alarm_irq_freq_out_oe_o, reset_out_o, reset_out_oe_o, lo, prev, a;
	logic [7:0] wb_adr_i, supply_level_i, r;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [2:0] xdiv;
	int miscompares, n_compared, rises, n, e;
	rtc_core #(.POR_CYCLES(200), .WDT_SHORT_CYCLES(300), .WDT_MID_CYCLES(600), .WDT_LONG_CYCLES(900)) i_dut (
		.core_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.xtal_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .supply_level_i, .alarm_irq_freq_out_o, .alarm_irq_freq_out_oe_o,
		.reset_out_o, .reset_out_oe_o);
	i2c_host i_host (.core_clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	// Fast time base (8 cycles) and edge count of the shared output
	always @(posedge core_clk_i) begin
		xdiv <= xdiv + 3'h1;
		xtal_i <= xdiv[2];
		prev <= alarm_irq_freq_out_oe_o;
		if (alarm_irq_freq_out_oe_o && !prev)
			rises <= rises + 1;
	end
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
		n_compared++;
		if (s !== ex) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, ex, s);
		end
	endtask
	// Page write of the eight clock bytes with a chosen high address
	task automatic wr(input logic [7:0] hi);
		i_host.start();
		i_host.xfer(8'hde, 1'b1, r, a);
		chk("ack", 1, 32'(a));
		i_host.xfer(hi, 1'b1, r, a);
		i_host.xfer(8'h30, 1'b1, r, a);
		for (int k = 0; k < 8; k++)
			i_host.xfer((k == 7) ? 8'h20 : 8'h01, 1'b1, r, a);
		i_host.stop();
	endtask
	task automatic final_report();
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge core_clk_i);
		miscompares++;
		final_report();
	end
	// Main sequence
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, xtal_i, prev, xdiv} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		supply_level_i = 8'hff;
		rst_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		wb(0, rtc_pkg::WB_STATUS, 0);
		chk("status", 32'h9, q);
		repeat (220) @(posedge core_clk_i);
		wb(0, rtc_pkg::WB_STATUS, 0);
		chk("status", 32'h1, q);
		wb(1, rtc_pkg::WB_CTRL, 32'h201);
		wb(0, rtc_pkg::WB_CTRL, 0);
		chk("ctrl", 32'h201, q);
		wb(0, 8'hfc, 0);
		chk("unmapped", 0, q);
		for (int f = 0; f < 4; f++) begin
			wb(1, rtc_pkg::WB_CTRL, 32'(f << rtc_pkg::C_FSEL));
			n = rises;
			repeat (512) @(posedge core_clk_i);
			n = rises - n;
			e = (f == 3) ? 64 : (f == 2) ? 8 : 0;
			chk("freq", 1, 32'(n >= e - 1 && n <= e + 1));
		end
		supply_level_i <= 8'h95;
		for (int t = 0; t < 8; t++) begin
			wb(1, rtc_pkg::WB_CTRL, 32'(t << rtc_pkg::C_THR));
			wb(0, rtc_pkg::WB_STATUS, 0);
			lo = supply_level_i < rtc_pkg::THR_TABLE[(t > 4) ? 4 : t];
			chk("low", 32'(lo), 32'(q[4]));
			if (lo)
				chk("rst", 1, 32'(reset_out_oe_o));
		end
		supply_level_i <= 8'h10;
		repeat (4) @(posedge core_clk_i);
		chk("vlow", 1, 32'(reset_out_oe_o));
		supply_level_i <= 8'hff;
		wb(1, rtc_pkg::WB_CTRL, 0);
		repeat (240) @(posedge core_clk_i);
		wb(1, rtc_pkg::WB_CTRL, 32'(rtc_pkg::WDT_SHORT) << rtc_pkg::C_WDT);
		repeat (310) @(posedge core_clk_i);
		wb(0, rtc_pkg::WB_STATUS, 0);
		chk("wdt", 1, 32'(q[3]));
		// Reset hold from the watchdog is still running: the select byte must go unanswered
		i_host.start();
		i_host.xfer(8'hde, 1'b1, r, a);
		chk("busrst", 0, 32'(a));
		i_host.stop();
		wb(1, rtc_pkg::WB_CTRL, 0);
		repeat (240) @(posedge core_clk_i);
		i_host.start();
		i_host.xfer(8'ha0, 1'b1, r, a);
		chk("sel", 0, 32'(a));
		i_host.stop();
		wr(8'h01);
		wb(0, rtc_pkg::WB_STATUS, 0);
		chk("halt", 1, 32'(q[0]));
		wr(8'h00);
		i_host.start();
		i_host.xfer(8'hde, 1'b1, r, a);
		i_host.xfer(8'h00, 1'b1, r, a);
		i_host.xfer(8'h30, 1'b1, r, a);
		i_host.start();
		i_host.xfer(8'hdf, 1'b1, r, a);
		for (int k = 0; k < 3; k++) begin
			i_host.xfer(8'hff, k == 2, r, a);
			chk("time", (k == 2) ? 32'h12 : 32'h0, 32'(r));
		end
		i_host.stop();
		final_report();
	end
endmodule
bind rtc_core rtc_chk #(.POR_CYCLES(POR_CYCLES)) i_chk (.core_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
	.wb_ack_o, .sda_o, .sda_oe_o, .supply_level_i, .alarm_irq_freq_out_o, .reset_out_o, .reset_out_oe_o);
